// File: src/safety_group_defines.svh
// Timing counts, codes and register offsets for the safety group tracker
`ifndef SAFETY_GROUP_DEFINES_SVH
`define SAFETY_GROUP_DEFINES_SVH

// State codes
`define STATE_RUN 8'h01
`define STATE_STOP 8'h02
`define STATE_ERROR 8'h04
`define STATE_RESET 8'h05
`define STATE_START 8'h06
`define STATE_HALTED 8'h07
`define STATE_DEACTIVE 8'h10
`define STATE_AWAIT 8'h11

// Diagnostic codes
`define DIAG_NONE 16'h0000
`define DIAG_BLOCK 16'h0001
`define DIAG_LINK 16'h0002
`define DIAG_UNIT 16'h0003
`define DIAG_ANALOG 16'h0004
`define DIAG_PASSIVATE 16'h0005
`define DIAG_RESTART 16'h0006

// Register byte offsets
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_IRQ_STATUS 12'h008
`define REG_IRQ_CLEAR 12'h00c
`define REG_IRQ_ENABLE 12'h010
`define REG_TIMEOUT 12'h014

// Control register fields
`define CTRL_MAP_STATE 0
`define CTRL_MAP_DIAG 1
`define CTRL_DEACTIVATE 2
`define CTRL_PASSIVATE 3
`define CTRL_RESET 32'h0000_0000

// Passivate timeout, milliseconds, reset default
`define PASSIVATE_TIMEOUT_MS 10000
`define CLK_MHZ 200
`define TIMEOUT_RESET 32'h0000_2710
`define CYCLES_PER_MS 18'h30d40

// Interrupt bits
`define IRQ_ERROR 0
`define IRQ_RUN 1
`define IRQ_STOP 2
`define IRQ_WIDTH 3

`endif

// File: src/safety_group_pkg.sv
// Types shared by the safety group tracker
package safety_group_pkg;

    typedef enum logic [7:0] {
        running_state = 8'b0000_0001,
        stopped_state = 8'b0000_0010,
        error_state = 8'b0000_0100,
        resetting_state = 8'b0000_1000,
        starting_state = 8'b0001_0000,
        halted_with_fault_state = 8'b0010_0000,
        deactive_state = 8'b0100_0000,
        await_link_fault_state = 8'b1000_0000
    } group_state_type;

    typedef struct packed {
        logic run;
        logic err_ack;
        logic unit_fault_in;
        logic link_fault;
        logic link_startup_done;
        logic block_fault;
        logic analog_mismatch;
        logic program_restart;
    } group_inputs_type;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_type;

    typedef struct packed {
        logic [7:0] state_code;
        logic [15:0] diag_code;
    } group_report_type;

endpackage : safety_group_pkg

// File: src/input_sync.sv
// Three-stage synchroniser with agreement of the last two stages
`timescale 1ns/1ps
module input_sync
    import safety_group_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire group_inputs_type raw,
    output group_inputs_type clean
);
    typedef struct packed {
        group_inputs_type s1;
        group_inputs_type s2;
        group_inputs_type s3;
        group_inputs_type held;
    } sync_type;

    sync_type q;
    sync_type next_q;

    always_comb begin
        next_q = q;
        next_q.s1 = raw;
        next_q.s2 = q.s1;
        next_q.s3 = q.s2;
        // Only the agreeing later stages move the held value
        for (int i = 0; i < $bits(group_inputs_type); i++) begin
            if (q.s2[i] == q.s3[i]) begin
                next_q.held[i] = q.s3[i];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            q <= '0;
        end else if (clk_en) begin
            q <= next_q;
        end
    end

    assign clean = q.held;
endmodule : input_sync

// File: src/safety_group_state_diag.sv
// Safety group state and diagnostic tracker with APB registers
`timescale 1ns/1ps
`include "safety_group_defines.svh"

// Overview of operation
// - Running only with run high, no error, all links started; stopped when run low
// - Error state reports code 4 with the error cause in the diagnostic
// - After error, causes cleared and acknowledge high gives resetting, code 5
// - Starting, code 6, while run high and links not yet started
// - At start or init, group with links enters halted with fault, code 7
// - Halted with fault moves to error when run goes high
// - Deactivated by setting reports code 16
// - Passivate setting reports code 17 while awaiting a link fault
// - Diagnostic 0 when no error, 1 when a function block faults
// - Diagnostic 2 when any assigned link is faulty
// - Diagnostic 3 when the unit fault input is high
// - Diagnostic 4 when analog inputs differ from saved values at start-up
// - Diagnostic 5 when passivate wait times out
// - Diagnostic 6 when the logic program was restarted
// - State and diagnostic mapped into process image when enabled
module safety_group_state_diag
    import safety_group_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic links_assigned,
    input wire group_inputs_type group_in,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [7:0] image_state,
    output logic [15:0] image_diag,
    output logic irq
);

    // ------------------------------------------------------------
    // Types and helpers
    // ------------------------------------------------------------
    typedef struct packed {
        group_state_type state;
        logic [15:0] diag;
        logic [31:0] ctrl;
        logic [31:0] timeout_ms;
        logic [17:0] ms_div;
        logic [31:0] ms_count;
        logic [`IRQ_WIDTH-1:0] irq_status;
        logic [`IRQ_WIDTH-1:0] irq_enable;
        logic [31:0] rdata;
        logic [7:0] img_state;
        logic [15:0] img_diag;
        logic started;
    } core_type;

    function automatic logic [7:0] state_code(input group_state_type s);
        unique case (s)
            running_state: state_code = `STATE_RUN;
            stopped_state: state_code = `STATE_STOP;
            error_state: state_code = `STATE_ERROR;
            resetting_state: state_code = `STATE_RESET;
            starting_state: state_code = `STATE_START;
            halted_with_fault_state: state_code = `STATE_HALTED;
            deactive_state: state_code = `STATE_DEACTIVE;
            await_link_fault_state: state_code = `STATE_AWAIT;
            default: state_code = 8'h00;
        endcase
    endfunction : state_code

    function automatic logic is_addr(input logic [11:0] a, input logic [11:0] r);
        is_addr = (a == r);
    endfunction : is_addr

    // ------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------
    group_inputs_type in_s;

    input_sync u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .clk_en(clk_en),
        .raw(group_in),
        .clean(in_s)
    );

    core_type q;
    core_type next_q;
    logic init_pending;

    logic any_cause;
    logic [15:0] cause_diag;
    logic timed_out;
    logic wr_cycle;
    logic rd_cycle;
    logic mapped;

    // Fixed priority: the worst cause wins when several coexist
    always_comb begin
        cause_diag = `DIAG_NONE;
        if (in_s.program_restart) begin
            cause_diag = `DIAG_RESTART;
        end else if (in_s.unit_fault_in) begin
            cause_diag = `DIAG_UNIT;
        end else if (in_s.link_fault) begin
            cause_diag = `DIAG_LINK;
        end else if (in_s.analog_mismatch && !q.started) begin
            cause_diag = `DIAG_ANALOG;
        end else if (in_s.block_fault) begin
            cause_diag = `DIAG_BLOCK;
        end
    end

    assign any_cause = (cause_diag != `DIAG_NONE);
    assign timed_out = (q.ms_count >= q.timeout_ms);
    assign wr_cycle = psel && penable && pwrite;
    assign rd_cycle = psel && !penable && !pwrite;
    assign mapped = is_addr(paddr, `REG_CTRL) || is_addr(paddr, `REG_STATUS)
        || is_addr(paddr, `REG_IRQ_STATUS) || is_addr(paddr, `REG_IRQ_CLEAR)
        || is_addr(paddr, `REG_IRQ_ENABLE) || is_addr(paddr, `REG_TIMEOUT);

    // ------------------------------------------------------------
    // Group state machine and registers
    // ------------------------------------------------------------
    always_comb begin
        next_q = q;
        next_q.ms_div = q.ms_div + 18'h1;
        if (q.ms_div == `CYCLES_PER_MS - 18'h1) begin
            next_q.ms_div = '0;
        end
        unique case (q.state)
            stopped_state: begin
                if (q.ctrl[`CTRL_DEACTIVATE]) begin
                    next_q.state = deactive_state;
                end else if (in_s.run) begin
                    next_q.state = starting_state;
                end
                next_q.diag = `DIAG_NONE;
            end
            halted_with_fault_state: begin
                if (in_s.run) begin
                    next_q.state = error_state;
                    next_q.diag = any_cause ? cause_diag : `DIAG_LINK;
                end
            end
            starting_state: begin
                if (!in_s.run) begin
                    next_q.state = stopped_state;
                end else if (any_cause) begin
                    next_q.state = error_state;
                    next_q.diag = cause_diag;
                end else if (in_s.link_startup_done) begin
                    next_q.state = running_state;
                    next_q.started = 1'b1;
                end
            end
            running_state: begin
                if (any_cause) begin
                    next_q.state = error_state;
                    next_q.diag = cause_diag;
                end else if (q.ctrl[`CTRL_PASSIVATE]) begin
                    next_q.state = await_link_fault_state;
                    next_q.ms_count = '0;
                end else if (!in_s.run) begin
                    next_q.state = stopped_state;
                end else if (!in_s.link_startup_done) begin
                    next_q.state = starting_state;
                end
            end
            await_link_fault_state: begin
                if (q.ms_div == `CYCLES_PER_MS - 18'h1) begin
                    next_q.ms_count = q.ms_count + 32'h1;
                end
                if (in_s.link_fault) begin
                    next_q.state = error_state;
                    next_q.diag = `DIAG_LINK;
                end else if (timed_out) begin
                    next_q.state = error_state;
                    next_q.diag = `DIAG_PASSIVATE;
                end
            end
            error_state: begin
                // Exit only via resetting; state is never cleared silently
                if (!any_cause && in_s.err_ack) begin
                    next_q.state = resetting_state;
                end
            end
            resetting_state: begin
                if (any_cause) begin
                    next_q.state = error_state;
                    next_q.diag = cause_diag;
                end else if (!in_s.err_ack) begin
                    next_q.diag = `DIAG_NONE;
                    next_q.state = in_s.run ? starting_state : stopped_state;
                end
            end
            deactive_state: begin
                if (!q.ctrl[`CTRL_DEACTIVATE]) begin
                    next_q.state = stopped_state;
                end
            end
        endcase

        // Interrupt events; a set beats a clear in the same cycle
        if (wr_cycle && is_addr(paddr, `REG_IRQ_CLEAR)) begin
            next_q.irq_status = q.irq_status & ~pwdata[`IRQ_WIDTH-1:0];
        end
        if (next_q.state == error_state && q.state != error_state) begin
            next_q.irq_status[`IRQ_ERROR] = 1'b1;
        end
        if (next_q.state == running_state && q.state != running_state) begin
            next_q.irq_status[`IRQ_RUN] = 1'b1;
        end
        if (next_q.state == stopped_state && q.state != stopped_state) begin
            next_q.irq_status[`IRQ_STOP] = 1'b1;
        end

        // APB writes
        if (wr_cycle && is_addr(paddr, `REG_CTRL)) begin
            next_q.ctrl = {28'h0, pwdata[3:0]};
        end
        if (wr_cycle && is_addr(paddr, `REG_IRQ_ENABLE)) begin
            next_q.irq_enable = pwdata[`IRQ_WIDTH-1:0];
        end
        if (wr_cycle && is_addr(paddr, `REG_TIMEOUT)) begin
            next_q.timeout_ms = pwdata;
        end

        // Read data captured in setup so the access phase needs no wait
        if (rd_cycle) begin
            next_q.rdata = 32'h0;
            if (is_addr(paddr, `REG_CTRL)) begin
                next_q.rdata = q.ctrl;
            end else if (is_addr(paddr, `REG_STATUS)) begin
                next_q.rdata = {8'h0, state_code(q.state), q.diag};
            end else if (is_addr(paddr, `REG_IRQ_STATUS)) begin
                next_q.rdata = {29'h0, q.irq_status};
            end else if (is_addr(paddr, `REG_IRQ_ENABLE)) begin
                next_q.rdata = {29'h0, q.irq_enable};
            end else if (is_addr(paddr, `REG_TIMEOUT)) begin
                next_q.rdata = q.timeout_ms;
            end
        end

        // Process image copy, zero when mapping is off
        next_q.img_state = q.ctrl[`CTRL_MAP_STATE] ? state_code(q.state) : 8'h00;
        next_q.img_diag = q.ctrl[`CTRL_MAP_DIAG] ? q.diag : 16'h0000;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            q.state <= stopped_state;
            q.diag <= `DIAG_NONE;
            q.ctrl <= `CTRL_RESET;
            q.timeout_ms <= `TIMEOUT_RESET;
            q.ms_div <= '0;
            q.ms_count <= '0;
            q.irq_status <= '0;
            q.irq_enable <= '0;
            q.rdata <= '0;
            q.img_state <= '0;
            q.img_diag <= '0;
            q.started <= 1'b0;
            init_pending <= 1'b1;
        end else if (clk_en) begin
            q <= next_q;
            // Strap caught after release, not under reset
            if (init_pending) begin
                init_pending <= 1'b0;
                if (links_assigned) begin
                    q.state <= halted_with_fault_state;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Bus and outputs
    // ------------------------------------------------------------
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = q.rdata;
    assign image_state = q.img_state;
    assign image_diag = q.img_diag;
    assign irq = |(q.irq_status & q.irq_enable);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_run_needs_start: assert property (@(posedge ref_clk) disable iff (rst)
        (q.state == starting_state && clk_en && in_s.run && !any_cause
         && in_s.link_startup_done) |=> q.state == running_state)
        else $error("run not entered after start-up");
    chk_stop_on_run_low: assert property (@(posedge ref_clk) disable iff (rst)
        (q.state == running_state && clk_en && !in_s.run && !any_cause
         && !q.ctrl[`CTRL_PASSIVATE]) |=> q.state == stopped_state)
        else $error("run low did not stop group");
    chk_error_diag: assert property (@(posedge ref_clk) disable iff (rst)
        (q.state == error_state) |-> (q.diag != `DIAG_NONE))
        else $error("error state without cause");
    chk_reset_path: assert property (@(posedge ref_clk) disable iff (rst)
        (q.state == error_state && clk_en && !any_cause && in_s.err_ack && !init_pending)
        |=> q.state == resetting_state)
        else $error("acknowledge did not reset group");
    chk_error_exit: assert property (@(posedge ref_clk) disable iff (rst)
        ($past(q.state) == error_state && q.state != error_state)
        |-> q.state == resetting_state)
        else $error("error left other than via reset");
    chk_halt_to_error: assert property (@(posedge ref_clk) disable iff (rst)
        (q.state == halted_with_fault_state && clk_en && in_s.run && !init_pending)
        |=> q.state == error_state)
        else $error("halted group ignored run");
    chk_timeout_diag: assert property (@(posedge ref_clk) disable iff (rst)
        (q.state == await_link_fault_state && clk_en && timed_out && !in_s.link_fault
         && !init_pending) |=> (q.state == error_state && q.diag == `DIAG_PASSIVATE))
        else $error("passivate timeout not reported");
    chk_image_copy: assert property (@(posedge ref_clk) disable iff (rst)
        (clk_en && !q.ctrl[`CTRL_MAP_STATE]) |=> image_state == 8'h00)
        else $error("state mapped while disabled");
    chk_stop_diag: assert property (@(posedge ref_clk) disable iff (rst)
        (q.state == stopped_state && clk_en && !init_pending) |=> q.diag == `DIAG_NONE)
        else $error("stopped group kept a diagnostic");
    chk_deactivate_entry: assert property (@(posedge ref_clk) disable iff (rst)
        (q.state == stopped_state && clk_en && q.ctrl[`CTRL_DEACTIVATE] && !init_pending)
        |=> q.state == deactive_state)
        else $error("deactivate setting ignored");

endmodule : safety_group_state_diag

// File: sim/link_partner.sv
// Far-side model of the group's safety connections
`timescale 1ns/1ps
module link_partner (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic start_req,
    input wire logic fault_req,
    input wire logic [7:0] start_delay,
    output logic startup_done,
    output logic fault
);
    logic [7:0] count;
    // A faulty link loses its start-up and has to start again
    always_ff @(posedge ref_clk) begin
        if (rst || !start_req || fault_req) begin
            count <= 8'h00;
            startup_done <= 1'b0;
        end else if (count >= start_delay) begin
            startup_done <= 1'b1;
        end else begin
            count <= count + 8'h01;
        end
        fault <= fault_req && !rst;
    end
endmodule : link_partner

// File: sim/safety_group_state_diag_tb.sv
// Self-checking bench for the safety group tracker
`timescale 1ns/1ps
`include "safety_group_defines.svh"
module safety_group_state_diag_tb;
    import safety_group_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic clk_en = 1'b1;
    logic links_assigned = 1'b1;
    logic [6:0] drv = 7'h00;
    logic start_req = 1'b0;
    logic [7:0] start_delay = 8'h04;
    logic lnk_done, lnk_fault, pready, pslverr, irq, err;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic [7:0] image_state;
    logic [15:0] image_diag;
    logic [3:0] ctrl = 4'h0;
    group_inputs_type group_in;
    int miscompares = 0;
    int check_count = 0;
    int ms = 2;
    int md = 0;
    int ran = 0;
    int tmo = `TIMEOUT_RESET;
    int r;
    assign group_in = '{drv[5], drv[4], drv[3], lnk_fault, lnk_done, drv[2], drv[1], drv[0]};
    initial forever #2.5 ref_clk = ~ref_clk;
    safety_group_state_diag i_dut (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en),
        .links_assigned(links_assigned), .group_in(group_in), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .image_state(image_state),
        .image_diag(image_diag), .irq(irq));
    link_partner i_link (.ref_clk(ref_clk), .rst(rst), .start_req(start_req),
        .fault_req(drv[6]), .start_delay(start_delay), .startup_done(lnk_done),
        .fault(lnk_fault));
    // ----------------------------------------
    // Reference model and shared tasks
    // ----------------------------------------
    function automatic void model();
        int c;
        for (int i = 0; i < 4; i++) begin
            c = drv[0] ? 6 : drv[3] ? 3 : lnk_fault ? 2 : (drv[1] && ran == 0) ? 4 : drv[2] ? 1 : 0;
            case (ms)
                7: if (drv[5]) begin ms = 4; md = (c != 0) ? c : 2; end
                2: if (ctrl[2]) begin ms = 16; end else if (drv[5]) begin ms = 6; end
                16: if (!ctrl[2]) begin ms = 2; end
                6, 1: if (!drv[5]) begin ms = 2; md = 0; end
                    else if (c != 0) begin ms = 4; md = c; end
                    else if (ms == 6 && lnk_done) begin ms = 1; ran = 1; end
                    else if (ms == 1 && ctrl[3]) begin ms = 17; end
                17: if (lnk_fault) begin ms = 4; md = 2; end
                    else if (tmo == 0) begin ms = 4; md = 5; end
                4: if (c != 0) begin md = c; end else if (drv[4]) begin ms = 5; md = -1; end
                5: if (!drv[4]) begin ms = drv[5] ? 6 : 2; md = 0; end
                default: ms = ms;
            endcase
        end
    endfunction : model
    task automatic cmp32(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : cmp32
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        cmp32("pready", 32'h1, {31'h0, pready});
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Outputs launched by the access edge are looked at once settled
        @(negedge ref_clk);
    endtask : apb
    task automatic wctrl(input logic [3:0] v);
        apb(1'b1, `REG_CTRL, {28'h0, v});
        ctrl = v;
    endtask : wctrl
    task automatic put(input logic [6:0] v);
        @(posedge ref_clk);
        drv <= v;
    endtask : put
    task automatic cmp_img();
        cmp32("image_state", ctrl[0] ? 32'(ms) : 32'h0, {24'h0, image_state});
        if (md >= 0) cmp32("image_diag", ctrl[1] ? 32'(md) : 32'h0, {16'h0, image_diag});
        apb(1'b0, `REG_STATUS, 32'h0);
        cmp32("status_state", 32'(ms), {24'h0, rd[23:16]});
        if (md >= 0) cmp32("status_diag", 32'(md), {16'h0, rd[15:0]});
    endtask : cmp_img
    // Latency is 4 sync edges plus state and image, slack covers slow start-up
    task automatic step();
        repeat (45) @(posedge ref_clk);
        model();
        cmp_img();
    endtask : step
    task automatic do_reset(input logic la);
        @(posedge ref_clk);
        rst <= 1'b1;
        links_assigned <= la;
        drv <= 7'h00;
        start_req <= 1'b0;
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        ms = la ? 7 : 2;
        md = la ? -1 : 0;
        ran = 0;
        ctrl = 4'h0;
        tmo = `TIMEOUT_RESET;
    endtask : do_reset
    task automatic results();
        $display("Checks %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : results
    initial begin
        #100000;
        miscompares++;
        results();
    end
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        void'($urandom(32'ha8b5));
        do_reset(1'b1);
        apb(1'b0, `REG_CTRL, 32'h0);
        cmp32("ctrl_reset", `CTRL_RESET, rd);
        apb(1'b0, `REG_TIMEOUT, 32'h0);
        cmp32("timeout_reset", `TIMEOUT_RESET, rd);
        apb(1'b0, 12'hff0, 32'h0);
        cmp32("unmapped_err", 32'h1, {31'h0, err});
        cmp32("unmapped_data", 32'h0, rd);
        step();
        wctrl(4'h3);
        step();
        put(7'h20);
        step();
        put(7'h30);
        step();
        put(7'h20);
        step();
        put(7'h22);
        step();
        put(7'h30);
        step();
        put(7'h20);
        start_req <= 1'b1;
        step();
        $display("Test start-up done");
        // Random causes with run held high; a link fault lands a cycle late,
        // so a block fault beside it is dropped to keep the first cause unique
        for (int k = 0; k < 6; k++) begin
            r = $urandom_range(1, 31);
            start_delay <= 8'($urandom_range(0, 30));
            put({r[4], 2'b10, r[3], r[2] & ~r[4], r[1], r[0]});
            step();
            put(7'h20);
            md = -1;
            step();
            put(7'h30);
            step();
            put(7'h20);
            step();
        end
        put(7'h22);
        step();
        $display("Test error causes done");
        put(7'h00);
        step();
        wctrl(4'h7);
        step();
        wctrl(4'h3);
        step();
        // Bus is frozen with the clock enable, so only the image is looked at
        clk_en <= 1'b0;
        put(7'h20);
        repeat (45) @(posedge ref_clk);
        cmp32("frozen_state", 32'(ms), {24'h0, image_state});
        cmp32("frozen_diag", 32'(md), {16'h0, image_diag});
        clk_en <= 1'b1;
        step();
        $display("Test stop and deactivate done");
        wctrl(4'hb);
        step();
        put(7'h60);
        step();
        wctrl(4'h3);
        put(7'h30);
        step();
        put(7'h20);
        step();
        // Zero timeout trips as soon as the group starts waiting
        apb(1'b1, `REG_TIMEOUT, 32'h0);
        tmo = 0;
        wctrl(4'hb);
        step();
        wctrl(4'h3);
        put(7'h30);
        step();
        put(7'h20);
        step();
        $display("Test passivate done");
        apb(1'b1, `REG_IRQ_CLEAR, 32'h7);
        apb(1'b1, `REG_IRQ_ENABLE, 32'h1);
        cmp32("irq_idle", 32'h0, {31'h0, irq});
        put(7'h24);
        step();
        cmp32("irq_raised", 32'h1, {31'h0, irq});
        apb(1'b0, `REG_IRQ_STATUS, 32'h0);
        cmp32("irq_status", 32'h1, rd & 32'h1);
        apb(1'b1, `REG_IRQ_ENABLE, 32'h0);
        cmp32("irq_masked", 32'h0, {31'h0, irq});
        apb(1'b1, `REG_IRQ_ENABLE, 32'h1);
        cmp32("irq_unmasked", 32'h1, {31'h0, irq});
        apb(1'b1, `REG_IRQ_CLEAR, 32'h1);
        apb(1'b0, `REG_IRQ_STATUS, 32'h0);
        cmp32("irq_cleared", 32'h0, rd & 32'h1);
        cmp32("irq_low", 32'h0, {31'h0, irq});
        wctrl(4'h0);
        step();
        $display("Test interrupt done");
        do_reset(1'b0);
        wctrl(4'h3);
        step();
        $display("Test second reset done");
        results();
    end
endmodule : safety_group_state_diag_tb
